// ### src/sdp_pkg.sv
package sdp_pkg;

  // ==========================================================================
  // Data formats and register file shape.
  // ==========================================================================
  localparam int DATA_W = 40;
  localparam int FIX_W = 32;
  localparam int REG_IDX_W = 4;
  localparam int REGS_PER_SET = 16;
  localparam int BUS_W = 64;
  localparam int FP_EXP_W = 8;
  localparam int FP_EXT_MAN_W = 31;
  localparam int FP_BIAS = 127;
  localparam logic [7:0] FP_EXP_MAX = 8'hff;
  localparam logic [DATA_W-1:0] ZERO40 = 40'h0;
  localparam logic [7:0] ZERO8 = 8'h00;

  // ==========================================================================
  // Operation codes.
  // ==========================================================================
  typedef enum logic [3:0] {
    SDP_ALU_NOP, SDP_ALU_ADD, SDP_ALU_SUB, SDP_ALU_AND, SDP_ALU_OR,
    SDP_ALU_XOR, SDP_ALU_PASS, SDP_ALU_FADD, SDP_ALU_FSUB, SDP_ALU_FABS
  } sdp_alu_op_t;

  typedef enum logic [1:0] {
    SDP_MUL_NOP, SDP_MUL_FIX, SDP_MUL_FLT
  } sdp_mul_op_t;

  typedef enum logic [2:0] {
    SDP_SH_NOP, SDP_SH_LSL, SDP_SH_LSR, SDP_SH_ASR, SDP_SH_ROT
  } sdp_sh_op_t;

  // ==========================================================================
  // Carriers.
  // ==========================================================================
  typedef struct packed {
    logic valid;
    sdp_alu_op_t aluOp;
    logic [REG_IDX_W-1:0] aluX;
    logic [REG_IDX_W-1:0] aluY;
    logic [REG_IDX_W-1:0] aluDst;
    sdp_mul_op_t mulOp;
    logic [REG_IDX_W-1:0] mulX;
    logic [REG_IDX_W-1:0] mulY;
    logic [REG_IDX_W-1:0] mulDst;
    sdp_sh_op_t shOp;
    logic [REG_IDX_W-1:0] shX;
    logic [5:0] shAmt;
    logic [REG_IDX_W-1:0] shDst;
  } sdp_instr_t;

  typedef struct packed {
    logic rdEn;
    logic [REG_IDX_W-1:0] rdIdx;
    logic wrEn;
    logic [REG_IDX_W-1:0] wrIdx;
    logic [BUS_W-1:0] wrData;
  } sdp_mem_xfer_t;

  typedef struct packed {
    logic zero;
    logic neg;
    logic carry;
    logic ovf;
  } sdp_flags_t;

endpackage

// ### src/sdp_datapath.sv
// Operation
// [RULE1] First element always runs; second only while its enable bit is set.
// [RULE2] In dual mode both elements execute each instruction on own data.
// [RULE3] Dual mode moves two values per bus access, one per element.
// [RULE4] Each element owns its ALU, multiplier, shifter and register file.
// [RULE5] ALU, multiplier and shifter are parallel and single cycle.
// [RULE6] Multifunction instruction runs ALU and multiplier together in each element.
// [RULE7] Supports single float, 40-bit extended float and 32-bit fixed point.
// [RULE8] Register file has ten ports, sixteen primary and sixteen secondary registers.
// [RULE9] Register files exchange bus data and hold intermediate results.
// [RULE10] Each element addresses its own set with indices 0 to 15.
// [RULE11] Two buses carry two 64-bit transfers every cycle.
// [RULE12] Primary set active after reset; secondary selected by mode bit.
// [RULE13] Disabled second element writes no registers, flags or transfers.
// [RULE14] Enable bit takes effect only at an instruction boundary.
`timescale 1ns/10ps
module sdp_datapath
  import sdp_pkg::*;
#(
  parameter int W = DATA_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire sdp_instr_t instr,
  input wire logic secondElementEnable,
  input wire logic secondarySelect,
  input wire sdp_mem_xfer_t pmXfer,
  input wire sdp_mem_xfer_t dmXfer,
  output logic [BUS_W-1:0] pmRdData,
  output logic [BUS_W-1:0] dmRdData,
  output sdp_flags_t firstFlags,
  output sdp_flags_t secondFlags,
  output logic simdActive
);

  // ==========================================================================
  // Mode latching.
  // ==========================================================================
  // Enable and bank select are sampled only when no instruction is valid,
  // so an instruction never sees the second element half enabled.
  logic simd_r;
  logic bank_r;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      simd_r <= 1'b0;
      bank_r <= 1'b0; // [RULE12]
    end else if (!instr.valid) begin
      simd_r <= secondElementEnable; // [RULE1] [RULE14]
      bank_r <= secondarySelect; // [RULE12]
    end
  end
  assign simdActive = simd_r;

  // ==========================================================================
  // Arithmetic helpers.
  // ==========================================================================
  function automatic logic [W-1:0] fpAdd(input logic [W-1:0] a, input logic [W-1:0] b);
    logic [W-1:0] big;
    logic [W-1:0] sml;
    logic [FP_EXP_W-1:0] d;
    logic [FP_EXT_MAN_W+1:0] mb;
    logic [FP_EXT_MAN_W+1:0] ms;
    logic [FP_EXT_MAN_W+2:0] s;
    logic [FP_EXP_W-1:0] e;
    logic [FP_EXT_MAN_W+2:0] n;
    big = (a[W-2 -: FP_EXP_W] >= b[W-2 -: FP_EXP_W]) ? a : b;
    sml = (a[W-2 -: FP_EXP_W] >= b[W-2 -: FP_EXP_W]) ? b : a;
    d = big[W-2 -: FP_EXP_W] - sml[W-2 -: FP_EXP_W];
    mb = {2'b01, big[FP_EXT_MAN_W-1:0]};
    ms = {2'b01, sml[FP_EXT_MAN_W-1:0]} >> d;
    e = big[W-2 -: FP_EXP_W];
    if (big[W-1] == sml[W-1]) begin
      s = {1'b0, mb} + {1'b0, ms};
    end else begin
      s = {1'b0, mb} - {1'b0, ms};
    end
    n = s;
    if (n[FP_EXT_MAN_W+1]) begin
      n = n >> 1;
      e = e + 8'h01;
    end else begin
      for (int i = 0; i < FP_EXT_MAN_W; i++) begin
        if (!n[FP_EXT_MAN_W] && n != '0 && e != ZERO8) begin
          n = n << 1;
          e = e - 8'h01;
        end
      end
    end
    if (n == '0 || big[W-2 -: FP_EXP_W] == ZERO8) begin
      fpAdd = (big[W-2 -: FP_EXP_W] == ZERO8) ? sml : ZERO40;
    end else begin
      fpAdd = {big[W-1], e, n[FP_EXT_MAN_W-1:0]};
    end
  endfunction

  function automatic logic [W-1:0] fpMul(input logic [W-1:0] a, input logic [W-1:0] b);
    logic [2*FP_EXT_MAN_W+1:0] p;
    logic [9:0] e;
    logic [FP_EXT_MAN_W-1:0] m;
    p = {1'b1, a[FP_EXT_MAN_W-1:0]} * {1'b1, b[FP_EXT_MAN_W-1:0]};
    e = 10'({2'b00, a[W-2 -: FP_EXP_W]} + {2'b00, b[W-2 -: FP_EXP_W]} - 10'(FP_BIAS));
    if (p[2*FP_EXT_MAN_W+1]) begin
      m = p[2*FP_EXT_MAN_W -: FP_EXT_MAN_W];
      e = e + 10'h001;
    end else begin
      m = p[2*FP_EXT_MAN_W-1 -: FP_EXT_MAN_W];
    end
    if (a[W-2 -: FP_EXP_W] == ZERO8 || b[W-2 -: FP_EXP_W] == ZERO8 || e[9]) begin
      fpMul = ZERO40;
    end else if (e[8]) begin
      fpMul = {a[W-1] ^ b[W-1], FP_EXP_MAX, {FP_EXT_MAN_W{1'b0}}};
    end else begin
      fpMul = {a[W-1] ^ b[W-1], e[7:0], m};
    end
  endfunction

  // ==========================================================================
  // Two processing elements.
  // ==========================================================================
  // Element 0 may write in any cycle; element 1 only while dual mode is latched.
  // Fixed point uses the top 32 bits; single float is extended float with
  // its low eight mantissa bits zero.
  logic [BUS_W/2-1:0] pmRd [2];
  logic [BUS_W/2-1:0] dmRd [2];
  sdp_flags_t flg [2];

  for (genvar pe = 0; pe < 2; pe++) begin : g_pe
    logic [W-1:0] rf_r [2*REGS_PER_SET]; // [RULE8] [RULE4]
    sdp_flags_t flags_r;
    logic [W-1:0] aluRes;
    logic [W-1:0] mulRes;
    logic [W-1:0] shRes;
    logic [FIX_W:0] fixSum;
    logic [2*FIX_W-1:0] fixProd;
    logic peOn;
    logic [REG_IDX_W:0] bankBase;
    assign peOn = (pe == 0) ? 1'b1 : simd_r; // [RULE1] [RULE13]
    assign bankBase = {bank_r, {REG_IDX_W{1'b0}}}; // [RULE10] [RULE12]

    // Returns a slot number, not a value, so every process names the array it reads in its own
    // expression and is woken when that array changes.
    function automatic logic [REG_IDX_W:0] slot(input logic [REG_IDX_W-1:0] idx, input logic [REG_IDX_W:0] base);
      slot = base + {1'b0, idx};
    endfunction

    // Single-cycle ALU, multiplier and shifter side by side.
    always_comb begin // [RULE5] [RULE7]
      logic [W-1:0] x;
      logic [W-1:0] y;
      x = rf_r[slot(instr.aluX, bankBase)];
      y = rf_r[slot(instr.aluY, bankBase)];
      fixSum = '0;
      case (instr.aluOp)
        SDP_ALU_ADD: fixSum = {1'b0, x[W-1 -: FIX_W]} + {1'b0, y[W-1 -: FIX_W]};
        SDP_ALU_SUB: fixSum = {1'b0, x[W-1 -: FIX_W]} - {1'b0, y[W-1 -: FIX_W]};
        default: fixSum = '0;
      endcase
      case (instr.aluOp)
        SDP_ALU_ADD, SDP_ALU_SUB: aluRes = {fixSum[FIX_W-1:0], 8'h00};
        SDP_ALU_AND: aluRes = x & y;
        SDP_ALU_OR: aluRes = x | y;
        SDP_ALU_XOR: aluRes = x ^ y;
        SDP_ALU_PASS: aluRes = x;
        SDP_ALU_FADD: aluRes = fpAdd(x, y);
        SDP_ALU_FSUB: aluRes = fpAdd(x, {~y[W-1], y[W-2:0]});
        SDP_ALU_FABS: aluRes = {1'b0, x[W-2:0]};
        default: aluRes = x;
      endcase
    end

    always_comb begin // [RULE5] [RULE7]
      logic [W-1:0] x;
      logic [W-1:0] y;
      x = rf_r[slot(instr.mulX, bankBase)];
      y = rf_r[slot(instr.mulY, bankBase)];
      fixProd = $signed(x[W-1 -: FIX_W]) * $signed(y[W-1 -: FIX_W]);
      case (instr.mulOp)
        SDP_MUL_FIX: mulRes = {fixProd[FIX_W-1:0], 8'h00};
        SDP_MUL_FLT: mulRes = fpMul(x, y);
        default: mulRes = ZERO40;
      endcase
    end

    always_comb begin // [RULE5]
      logic [W-1:0] x;
      logic [FIX_W-1:0] v;
      x = rf_r[slot(instr.shX, bankBase)];
      v = x[W-1 -: FIX_W];
      case (instr.shOp)
        SDP_SH_LSL: v = v << instr.shAmt;
        SDP_SH_LSR: v = v >> instr.shAmt;
        SDP_SH_ASR: v = FIX_W'($signed(v) >>> instr.shAmt);
        SDP_SH_ROT: v = (v << instr.shAmt[4:0]) | (v >> (6'(FIX_W) - {1'b0, instr.shAmt[4:0]}));
        default: v = x[W-1 -: FIX_W];
      endcase
      shRes = {v, 8'h00};
    end

    // Register file write ports: three units plus two bus loads. Later
    // writers win on an index clash; bus loads take priority over units.
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        for (int i = 0; i < 2*REGS_PER_SET; i++) begin
          rf_r[i] <= ZERO40;
        end
      end else if (peOn) begin // [RULE13]
        if (instr.valid && instr.aluOp != SDP_ALU_NOP) begin
          rf_r[bankBase + {1'b0, instr.aluDst}] <= aluRes; // [RULE6] [RULE2]
        end
        if (instr.valid && instr.mulOp != SDP_MUL_NOP) begin
          rf_r[bankBase + {1'b0, instr.mulDst}] <= mulRes; // [RULE6] [RULE2]
        end
        if (instr.valid && instr.shOp != SDP_SH_NOP) begin
          rf_r[bankBase + {1'b0, instr.shDst}] <= shRes;
        end
        if (pmXfer.wrEn) begin
          rf_r[bankBase + {1'b0, pmXfer.wrIdx}] <= {pmXfer.wrData[pe*FIX_W +: FIX_W], 8'h00}; // [RULE3] [RULE9]
        end
        if (dmXfer.wrEn) begin
          rf_r[bankBase + {1'b0, dmXfer.wrIdx}] <= {dmXfer.wrData[pe*FIX_W +: FIX_W], 8'h00}; // [RULE3] [RULE9]
        end
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_b) begin
        flags_r <= '0;
      end else if (peOn && instr.valid && instr.aluOp != SDP_ALU_NOP) begin // [RULE13]
        flags_r.zero <= (aluRes == ZERO40);
        flags_r.neg <= aluRes[W-1];
        flags_r.carry <= fixSum[FIX_W];
        flags_r.ovf <= (aluRes[W-2 -: FP_EXP_W] == FP_EXP_MAX);
      end
    end

    assign pmRd[pe] = (peOn && pmXfer.rdEn) ? rf_r[slot(pmXfer.rdIdx, bankBase)][W-1 -: FIX_W] : '0; // [RULE11]
    assign dmRd[pe] = (peOn && dmXfer.rdEn) ? rf_r[slot(dmXfer.rdIdx, bankBase)][W-1 -: FIX_W] : '0;
    assign flg[pe] = flags_r;
  end

  // ==========================================================================
  // Read data registers: both buses every cycle, element 1 in the high word.
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pmRdData <= '0;
      dmRdData <= '0;
    end else begin
      pmRdData <= {pmRd[1], pmRd[0]}; // [RULE3] [RULE11]
      dmRdData <= {dmRd[1], dmRd[0]}; // [RULE3] [RULE11]
    end
  end

  assign firstFlags = flg[0];
  assign secondFlags = flg[1];

endmodule

// ### dv/sdp_datapath_sva.sv
`timescale 1ns/10ps
// ==========================================================================
// Port checker for the dual element datapath.
// ==========================================================================
module sdp_datapath_sva
  import sdp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire sdp_instr_t instr,
  input wire logic secondElementEnable,
  input wire logic secondarySelect,
  input wire sdp_mem_xfer_t pmXfer,
  input wire sdp_mem_xfer_t dmXfer,
  input wire logic [BUS_W-1:0] pmRdData,
  input wire logic [BUS_W-1:0] dmRdData,
  input wire sdp_flags_t firstFlags,
  input wire sdp_flags_t secondFlags,
  input wire logic simdActive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Two edges with element two off, so a late write cannot hide.
  sequence s_single2;
    !simdActive ##1 !simdActive;
  endsequence
  sequence s_read_single;
    (pmXfer.rdEn || dmXfer.rdEn) ##0 s_single2;
  endsequence
  AST_ENTER_SIMD: assert property (!instr.valid && secondElementEnable |=> simdActive)
    else $error("dual mode not entered");
  AST_LEAVE_SIMD: assert property (!instr.valid && !secondElementEnable |=> !simdActive)
    else $error("dual mode not left");
  AST_MODE_HELD: assert property (instr.valid |=> $stable(simdActive))
    else $error("mode changed inside an instruction");
  AST_RISE_CAUSE: assert property ($rose(simdActive) |-> $past(secondElementEnable) && !$past(instr.valid))
    else $error("dual mode rose without a boundary");
  AST_PM_READ_IDLE: assert property (!pmXfer.rdEn |=> pmRdData == 64'h0)
    else $error("program bus read data without request");
  AST_DM_READ_IDLE: assert property (!dmXfer.rdEn |=> dmRdData == 64'h0)
    else $error("data bus read data without request");
  AST_SECOND_READ_OFF: assert property (s_read_single |-> pmRdData[63:32] == 32'h0 && dmRdData[63:32] == 32'h0)
    else $error("disabled element two returned data");
  AST_SECOND_FLAGS_OFF: assert property (s_single2 |-> $stable(secondFlags))
    else $error("disabled element two changed flags");
  AST_FLAGS_HOLD: assert property (!instr.valid || instr.aluOp == SDP_ALU_NOP |=> $stable(firstFlags))
    else $error("flags moved without an alu operation");
endmodule

// ### dv/sdp_seq_model.sv
`timescale 1ns/10ps
// ==========================================================================
// Sequencer and bus side model.
// ==========================================================================
module sdp_seq_model
  import sdp_pkg::*;
(
  input wire logic clk,
  output sdp_instr_t instr,
  output logic secondElementEnable,
  output logic secondarySelect,
  output sdp_mem_xfer_t pmXfer,
  output sdp_mem_xfer_t dmXfer
);
  initial begin
    instr = '0;
    secondElementEnable = 1'b0;
    secondarySelect = 1'b0;
    pmXfer = '0;
    dmXfer = '0;
  end
  // Two cycles per call, an idle one then the driven one; released write data is inverted so stale data never matches.
  task automatic drive(input sdp_instr_t i, input sdp_mem_xfer_t p, input sdp_mem_xfer_t d, input logic en,
                       input logic sel);
    @(posedge clk);
    instr <= i;
    pmXfer <= p;
    dmXfer <= d;
    secondElementEnable <= en;
    secondarySelect <= sel;
    @(posedge clk);
    instr <= '0;
    pmXfer <= '{rdEn:1'b0, rdIdx:p.rdIdx, wrEn:1'b0, wrIdx:p.wrIdx, wrData:~p.wrData};
    dmXfer <= '{rdEn:1'b0, rdIdx:d.rdIdx, wrEn:1'b0, wrIdx:d.wrIdx, wrData:~d.wrData};
  endtask
endmodule

// ### dv/sdp_datapath_tb_top.sv
`timescale 1ns/10ps
module sdp_datapath_tb_top;
  import sdp_pkg::*;
  logic clk;
  logic rst_b;
  sdp_instr_t instr;
  logic secondElementEnable;
  logic secondarySelect;
  sdp_mem_xfer_t pmXfer;
  sdp_mem_xfer_t dmXfer;
  logic [BUS_W-1:0] pmRdData;
  logic [BUS_W-1:0] dmRdData;
  sdp_flags_t firstFlags;
  sdp_flags_t secondFlags;
  logic simdActive;
  logic simdOn = 1'b0;
  logic bankSel = 1'b0;
  int badCount = 0;
  int totalChecks = 0;
  localparam sdp_mem_xfer_t NOX = '0;
  localparam sdp_instr_t NOI = '0;

  sdp_datapath i_dut (.clk(clk), .rst_b(rst_b), .instr(instr), .secondElementEnable(secondElementEnable),
    .secondarySelect(secondarySelect), .pmXfer(pmXfer), .dmXfer(dmXfer), .pmRdData(pmRdData),
    .dmRdData(dmRdData), .firstFlags(firstFlags), .secondFlags(secondFlags), .simdActive(simdActive));
  sdp_seq_model i_seq (.clk(clk), .instr(instr), .secondElementEnable(secondElementEnable),
    .secondarySelect(secondarySelect), .pmXfer(pmXfer), .dmXfer(dmXfer));

  // ==========================================================================
  // Helpers.
  // ==========================================================================
  function automatic sdp_mem_xfer_t wr(input logic [3:0] idx, input logic [63:0] d);
    return '{rdEn:1'b0, rdIdx:4'h0, wrEn:1'b1, wrIdx:idx, wrData:d};
  endfunction
  function automatic sdp_mem_xfer_t rd(input logic [3:0] idx);
    return '{rdEn:1'b1, rdIdx:idx, wrEn:1'b0, wrIdx:4'h0, wrData:64'h0};
  endfunction
  function automatic sdp_instr_t alu(input sdp_alu_op_t op, input logic [3:0] dst);
    return '{valid:1'b1, aluOp:op, aluX:4'h1, aluY:4'h2, aluDst:dst, mulOp:SDP_MUL_NOP, shOp:SDP_SH_NOP,
      default:'0};
  endfunction
  task automatic step(input sdp_instr_t i, input sdp_mem_xfer_t p, input sdp_mem_xfer_t d);
    i_seq.drive(i, p, d, simdOn, bankSel);
    #1;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  task automatic t_single();
    step(NOI, rd(4'h0), rd(4'hf));
    check(pmRdData | dmRdData, 64'h0);
    step(NOI, wr(4'h3, 64'hdead_beef_1234_5678), NOX);
    step(NOI, NOX, rd(4'h3));
    check(dmRdData, 64'h0000_0000_1234_5678);
  endtask
  task automatic t_simd();
    sdp_instr_t i;
    simdOn = 1'b1;
    step(NOI, wr(4'h5, 64'hffff_ffff_ffff_ffff), NOX);
    check({63'h0, simdActive}, 64'h1);
    step(NOI, wr(4'h1, {32'h1e, 32'h5}), wr(4'h2, {32'h14, 32'h7}));
    step(NOI, wr(4'h5, 64'hffff_ffff_ffff_ffff), rd(4'h2));
    check(dmRdData, {32'h14, 32'h7});
    i = alu(SDP_ALU_ADD, 4'h4);
    i.mulOp = SDP_MUL_FIX;
    i.mulDst = 4'h5;
    i.mulX = 4'h1;
    i.mulY = 4'h2;
    i.shOp = SDP_SH_LSL;
    i.shX = 4'h1;
    i.shAmt = 6'h04;
    i.shDst = 4'h6;
    step(i, NOX, NOX);
    step(NOI, rd(4'h4), rd(4'h5));
    check(pmRdData, {32'h32, 32'hc});
    check(dmRdData, {32'h258, 32'h23});
    step(NOI, rd(4'h6), rd(4'h1));
    check(pmRdData, {32'h1e0, 32'h50});
    check(dmRdData, {32'h1e, 32'h5});
    step(alu(SDP_ALU_SUB, 4'h7), NOX, NOX);
    check({60'h0, firstFlags}, 64'h7);
    check({60'h0, secondFlags}, 64'h0);
  endtask
  task automatic t_boundary();
    simdOn = 1'b0;
    step(alu(SDP_ALU_ADD, 4'h8), NOX, NOX);
    check({63'h0, simdActive}, 64'h1);
    step(NOI, NOX, NOX);
    check({63'h0, simdActive}, 64'h0);
    step(NOI, rd(4'h8), NOX);
    check(pmRdData, {32'h0, 32'hc});
  endtask
  task automatic t_bank();
    bankSel = 1'b1;
    step(NOI, NOX, NOX);
    step(NOI, rd(4'h4), NOX);
    check(pmRdData, 64'h0);
    bankSel = 1'b0;
    step(NOI, NOX, NOX);
    step(NOI, rd(4'h4), NOX);
    check(pmRdData, {32'h0, 32'hc});
  endtask
  // Single floats load as extended floats with a zero low byte, so reads hand them back as they are.
  task automatic t_formats();
    sdp_instr_t i;
    simdOn = 1'b1;
    step(NOI, NOX, NOX);
    step(NOI, wr(4'h1, {32'h4000_0000, 32'h3fc0_0000}), wr(4'h2, {32'hbf00_0000, 32'h4020_0000}));
    i = alu(SDP_ALU_FADD, 4'h3);
    i.mulOp = SDP_MUL_FLT;
    i.mulX = 4'h1;
    i.mulY = 4'h2;
    i.mulDst = 4'h4;
    step(i, NOX, NOX);
    step(NOI, rd(4'h3), rd(4'h4));
    check(pmRdData, {32'h3fc0_0000, 32'h4080_0000});
    check(dmRdData, {32'hbf80_0000, 32'h4070_0000});
    step(alu(SDP_ALU_FSUB, 4'h5), NOX, NOX);
    i = alu(SDP_ALU_FABS, 4'h6);
    i.aluX = 4'h5;
    step(i, NOX, NOX);
    step(NOI, rd(4'h5), rd(4'h6));
    check(pmRdData, {32'h4020_0000, 32'hbf80_0000});
    check(dmRdData, {32'h4020_0000, 32'h3f80_0000});
    i = alu(SDP_ALU_XOR, 4'h7);
    i.aluY = 4'h6;
    i.shOp = SDP_SH_ASR;
    i.shX = 4'h2;
    i.shAmt = 6'h04;
    i.shDst = 4'h8;
    step(i, NOX, NOX);
    step(NOI, rd(4'h7), rd(4'h8));
    check(pmRdData, {32'h0020_0000, 32'h0040_0000});
    check(dmRdData, {32'hfbf0_0000, 32'h0402_0000});
    i.aluOp = SDP_ALU_AND;
    i.aluDst = 4'h9;
    i.shOp = SDP_SH_ROT;
    i.shX = 4'h1;
    i.shDst = 4'ha;
    step(i, NOX, NOX);
    step(NOI, rd(4'h9), rd(4'ha));
    check(pmRdData, {32'h4000_0000, 32'h3f80_0000});
    check(dmRdData, {32'h0000_0004, 32'hfc00_0003});
    i.aluOp = SDP_ALU_OR;
    i.aluDst = 4'hb;
    i.shOp = SDP_SH_LSR;
    i.shX = 4'h2;
    i.shAmt = 6'h08;
    i.shDst = 4'hc;
    step(i, NOX, NOX);
    step(NOI, rd(4'hb), rd(4'hc));
    check(pmRdData, {32'h4020_0000, 32'h3fc0_0000});
    check(dmRdData, {32'h00bf_0000, 32'h0040_2000});
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (500) @(posedge clk);
    badCount++;
    results();
  end
  initial begin
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_single();
    t_simd();
    t_boundary();
    t_bank();
    t_formats();
    results();
  end
endmodule

bind sdp_datapath sdp_datapath_sva i_sva (.clk(clk), .rst_b(rst_b), .instr(instr),
  .secondElementEnable(secondElementEnable), .secondarySelect(secondarySelect), .pmXfer(pmXfer),
  .dmXfer(dmXfer), .pmRdData(pmRdData), .dmRdData(dmRdData), .firstFlags(firstFlags),
  .secondFlags(secondFlags), .simdActive(simdActive));
